/* src/twl_defines.vh */
// constants for the two-wire debug link target
`ifndef TWL_DEFINES_VH
`define TWL_DEFINES_VH

`define TWL_SEL_PART_ID    8'h00
`define TWL_SEL_REVISION   8'h01
`define TWL_SEL_FP_CONTROL 8'h02
`define TWL_SEL_FP_DATA    8'hb4

`define TWL_RESET_SELECT   8'h00
`define TWL_RESET_FP_CTL   8'h00
`define TWL_RESET_FP_DAT   8'h00

`define TWL_CMD_BLOCK_READ  8'h06
`define TWL_CMD_BLOCK_WRITE 8'h07
`define TWL_CMD_PAGE_ERASE  8'h08
`define TWL_CMD_DEV_ERASE   8'h03

`define TWL_INS_DATA_READ  2'b00
`define TWL_INS_DATA_WRITE 2'b01
`define TWL_INS_ADDR_READ  2'b10
`define TWL_INS_ADDR_WRITE 2'b11
`define TWL_INS_BIT_WRITE  0
`define TWL_INS_BIT_ADDR   1

`define TWL_CLK_PERIOD_NS  5
`define TWL_ABORT_LOW_NS   1000
`define TWL_ABORT_CYCLES   8'd200

`endif

/* src/twl_sync.v */
// two-flop synchroniser for one asynchronous level
`timescale 1ns/1ps
`default_nettype none

module twl_sync (
  input  wire clk_sys,
  input  wire rst,
  input  wire asyncIn,
  output wire syncOut
);

  reg stage1_reg;
  reg stage2_reg;

  // stage1 feeds stage2 only
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      stage1_reg <= 1'b1;
      stage2_reg <= 1'b1;
    end else begin
      stage1_reg <= asyncIn;
      stage2_reg <= stage1_reg;
    end
  end

  assign syncOut = stage2_reg;

endmodule // twl_sync

`default_nettype wire

/* src/twl_port.v */
// target side of the two-wire debug and flash programming link
`timescale 1ns/1ps
`default_nettype none
`include "twl_defines.vh"

// Contract
// - the link uses one host-driven clock line and one two-way data line.
// - the select register, written over the link, picks the data register.
// - select 0x00 makes data reads return the part identifier.
// - select 0x01 makes data reads return the silicon revision.
// - select 0x02 gives read and write access to flash program control.
// - select 0xb4 gives read and write access to the flash program data.
// - flash commands, addresses and data are accepted in the data register.
// - data-register codes 0x06, 0x07, 0x08, 0x03 decode as flash commands.
// - link traffic is served only while the device is halted.
// - while halted the link takes the reset pin and the shared port pin.
module twl_port #(
  parameter [7:0] PART_ID  = 8'h5a,  // arbitrary value
  parameter [7:0] REVISION = 8'h01   // arbitrary value
) (
  input  wire       clk_sys,
  input  wire       rst,
  input  wire       haltIn,
  input  wire       debugClockLine,
  input  wire       debugDataIn,
  output reg        debugDataOut,
  output reg        debugDataOeN,
  output wire       resetPinToLink,
  output wire       portPinToLink,
  output wire [7:0] fpControl,
  output reg  [7:0] flashWriteData,
  output reg        flashDataStrobe,
  output reg        cmdBlockRead,
  output reg        cmdBlockWrite,
  output reg        cmdPageErase,
  output reg        cmdDeviceErase,
  input  wire       flashReadLoad,
  input  wire [7:0] flashReadData,
  output wire       linkBusy
);

  localparam [2:0] ST_IDLE  = 3'd0;
  localparam [2:0] ST_INS   = 3'd1;
  localparam [2:0] ST_WDATA = 3'd2;
  localparam [2:0] ST_RDATA = 3'd3;

  // least low time in whole system cycles, held at the counter's width
  localparam [7:0] ABORT_CYCLES = `TWL_ABORT_CYCLES;

  wire [1:0] pinRaw;
  wire [1:0] pinSync;
  wire       ckSync;
  wire       dSync;
  reg        ckPrev_reg;
  wire       ckRise;
  wire       ckFall;

  reg  [2:0] state_reg;
  reg  [2:0] bitCnt_reg;
  reg  [1:0] ins_reg;
  reg  [7:0] shift_reg;
  reg  [7:0] select_reg;
  reg  [7:0] flash_program_control_reg;
  reg  [7:0] flash_program_data_reg;
  reg  [7:0] lowCnt_reg;

  assign pinRaw = {debugDataIn, debugClockLine};

  // pins come from the host's domain
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_sync
      twl_sync u_sync (
        .clk_sys (clk_sys),
        .rst     (rst),
        .asyncIn (pinRaw[gi]),
        .syncOut (pinSync[gi])
      );
    end
  endgenerate

  assign ckSync = pinSync[0];
  assign dSync  = pinSync[1];
  assign ckRise = ckSync & ~ckPrev_reg;
  assign ckFall = ~ckSync & ckPrev_reg;

  assign resetPinToLink = haltIn;
  assign portPinToLink  = haltIn;
  assign fpControl      = flash_program_control_reg;
  assign linkBusy       = (state_reg != ST_IDLE);

  // decodes a select value into a one-hot register choice
  function [3:0] selDecode;
    input [7:0] sel;
    begin
      selDecode = 4'b0000;
      case (sel)
        `TWL_SEL_PART_ID:    selDecode = 4'b0001;
        `TWL_SEL_REVISION:   selDecode = 4'b0010;
        `TWL_SEL_FP_CONTROL: selDecode = 4'b0100;
        `TWL_SEL_FP_DATA:    selDecode = 4'b1000;
        default:             selDecode = 4'b0000;
      endcase
    end
  endfunction

  wire [3:0] selHot = selDecode(select_reg);
  wire [7:0] wrByte = {dSync, shift_reg[7:1]};
  // a halt dropped on the last bit must not let the write land
  wire       wrDone = ckRise & haltIn & (state_reg == ST_WDATA) &
                      (bitCnt_reg == 3'd7);
  wire       wrData = wrDone & ~ins_reg[`TWL_INS_BIT_ADDR];

  reg [7:0] readValue;
  always @* begin
    readValue = 8'h00;
    if (ins_reg[`TWL_INS_BIT_ADDR])
      readValue = select_reg;
    else if (selHot[0])
      readValue = PART_ID;
    else if (selHot[1])
      readValue = REVISION;
    else if (selHot[2])
      readValue = flash_program_control_reg;
    else if (selHot[3])
      readValue = flash_program_data_reg;
  end

  // sequencer: start bit, two instruction bits, eight data bits lsb first
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ckPrev_reg <= 1'b1;
      state_reg  <= ST_IDLE;
      bitCnt_reg <= 3'd0;
      ins_reg    <= 2'b00;
      shift_reg  <= 8'h00;
      lowCnt_reg <= 8'h00;
    end else begin
      ckPrev_reg <= ckSync;
      // a long low clock abandons any frame
      if (ckSync)
        lowCnt_reg <= 8'h00;
      else if (lowCnt_reg != ABORT_CYCLES)
        lowCnt_reg <= lowCnt_reg + 8'h01;
      if (!haltIn || lowCnt_reg == ABORT_CYCLES) begin
        state_reg <= ST_IDLE;
      end else if (ckRise) begin
        case (state_reg)
          ST_IDLE: begin
            if (!dSync) begin
              state_reg  <= ST_INS;
              bitCnt_reg <= 3'd0;
            end
          end
          ST_INS: begin
            ins_reg <= {dSync, ins_reg[1]};
            if (bitCnt_reg == 3'd1) begin
              bitCnt_reg <= 3'd0;
              if (ins_reg[1])
                state_reg <= ST_WDATA;
              else
                state_reg <= ST_RDATA;
            end else begin
              bitCnt_reg <= bitCnt_reg + 3'd1;
            end
          end
          ST_WDATA: begin
            shift_reg  <= wrByte;
            bitCnt_reg <= bitCnt_reg + 3'd1;
            if (bitCnt_reg == 3'd7)
              state_reg <= ST_IDLE;
          end
          ST_RDATA: begin
            bitCnt_reg <= bitCnt_reg + 3'd1;
            if (bitCnt_reg == 3'd7)
              state_reg <= ST_IDLE;
          end
          default: state_reg <= ST_IDLE;
        endcase
      end
    end
  end

  // device drives after the falling edge so the host samples a stable bit
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      debugDataOut <= 1'b1;
      debugDataOeN <= 1'b1;
    end else if (state_reg == ST_RDATA && haltIn) begin
      if (ckFall) begin
        debugDataOut <= readValue[bitCnt_reg];
        debugDataOeN <= 1'b0;
      end
    end else if (ckFall || !haltIn || state_reg != ST_RDATA) begin
      debugDataOeN <= 1'b1;
      debugDataOut <= 1'b1;
    end
  end

  // register writes land on the eighth data bit
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      select_reg      <= `TWL_RESET_SELECT;
      flash_program_control_reg       <= `TWL_RESET_FP_CTL;
      flash_program_data_reg       <= `TWL_RESET_FP_DAT;
      flashWriteData  <= 8'h00;
      flashDataStrobe <= 1'b0;
      cmdBlockRead    <= 1'b0;
      cmdBlockWrite   <= 1'b0;
      cmdPageErase    <= 1'b0;
      cmdDeviceErase  <= 1'b0;
    end else begin
      flashDataStrobe <= 1'b0;
      cmdBlockRead    <= 1'b0;
      cmdBlockWrite   <= 1'b0;
      cmdPageErase    <= 1'b0;
      cmdDeviceErase  <= 1'b0;
      if (wrDone && ins_reg[`TWL_INS_BIT_ADDR])
        select_reg <= wrByte;
      if (wrData && selHot[2])
        flash_program_control_reg <= wrByte;
      // link write wins over a flash readback in the same cycle
      if (wrData && selHot[3]) begin
        flash_program_data_reg       <= wrByte;
        flashWriteData  <= wrByte;
        flashDataStrobe <= 1'b1;
        cmdBlockRead    <= (wrByte == `TWL_CMD_BLOCK_READ);
        cmdBlockWrite   <= (wrByte == `TWL_CMD_BLOCK_WRITE);
        cmdPageErase    <= (wrByte == `TWL_CMD_PAGE_ERASE);
        cmdDeviceErase  <= (wrByte == `TWL_CMD_DEV_ERASE);
      end else if (flashReadLoad) begin
        flash_program_data_reg <= flashReadData;
      end
      // identifier and unknown selects fall through untouched
    end
  end

endmodule // twl_port

`default_nettype wire

/* sim/twl_port_assertions.sv */
// port checker for the two-wire link target
`timescale 1ns/1ps
`default_nettype none
module twl_port_checker (
  input wire logic       clk_sys,
  input wire logic       rst,
  input wire logic       haltIn,
  input wire logic       debugDataOut,
  input wire logic       debugDataOeN,
  input wire logic       resetPinToLink,
  input wire logic       portPinToLink,
  input wire logic [7:0] fpControl,
  input wire logic [7:0] flashWriteData,
  input wire logic       flashDataStrobe,
  input wire logic       cmdBlockRead,
  input wire logic       cmdBlockWrite,
  input wire logic       cmdPageErase,
  input wire logic       cmdDeviceErase,
  input wire logic       linkBusy
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  pin_share_a: assert property (
    resetPinToLink == haltIn && portPinToLink == haltIn)
    else $error("pins not handed to link on halt");
  cmd_has_strobe_a: assert property (
    (cmdBlockRead || cmdBlockWrite || cmdPageErase || cmdDeviceErase)
    |-> flashDataStrobe)
    else $error("command pulse without data write");
  cmd_rw_decode_a: assert property (
    flashDataStrobe |-> cmdBlockRead == (flashWriteData == 8'h06) &&
    cmdBlockWrite == (flashWriteData == 8'h07))
    else $error("block command decode wrong");
  cmd_erase_decode_a: assert property (
    flashDataStrobe |-> cmdPageErase == (flashWriteData == 8'h08) &&
    cmdDeviceErase == (flashWriteData == 8'h03))
    else $error("erase command decode wrong");
  strobe_single_a: assert property (
    flashDataStrobe |=> !flashDataStrobe)
    else $error("data strobe longer than one cycle");
  wdata_on_strobe_a: assert property (
    $changed(flashWriteData) |-> flashDataStrobe)
    else $error("data byte changed without write");
  ctl_needs_halt_a: assert property (
    $changed(fpControl) |-> $past(haltIn))
    else $error("control written while running");
  idle_release_a: assert property (
    !haltIn [*3] |-> debugDataOeN && !linkBusy)
    else $error("link active while running");
  released_high_a: assert property (
    debugDataOeN |-> debugDataOut)
    else $error("released line not high");
endmodule // twl_port_checker
bind twl_port twl_port_checker u_chk (.clk_sys, .rst, .haltIn, .debugDataOut,
  .debugDataOeN, .resetPinToLink, .portPinToLink, .fpControl, .flashWriteData,
  .flashDataStrobe, .cmdBlockRead, .cmdBlockWrite, .cmdPageErase,
  .cmdDeviceErase, .linkBusy);
`default_nettype wire

/* sim/twl_host.sv */
// host adapter model driving the link clock and data line
`timescale 1ns/1ps
`default_nettype none
module twl_host (
  output logic      clkLine,
  output logic      hostOe,
  output logic      hostBit,
  input  wire logic dataLine
);
  initial begin
    clkLine = 1'h1;
    hostOe = 1'h0;
    hostBit = 1'h1;
  end
  // clock idles high, so each bit is a low half then a sampling rise
  task automatic tick(input logic b, input logic oe, output logic s);
    clkLine = 1'h0;
    hostOe = oe;
    hostBit = b;
    #24;
    clkLine = 1'h1;
    s = dataLine;
    #24;
  endtask
  task automatic frame(input logic [1:0] ins, input logic [7:0] wd,
                       output logic [7:0] rd);
    logic s;
    tick(1'h0, 1'h1, s);
    for (int i = 0; i < 2; i++) tick(ins[i], 1'h1, s);
    for (int i = 0; i < 8; i++) begin
      tick(wd[i], ins[0], s);
      rd[i] = s;
    end
    // released pulse: device lets go before the next start bit
    tick(1'h1, 1'h0, s);
  endtask
endmodule // twl_host
`default_nettype wire

/* sim/tb_top.sv */
// self-checking bench for the two-wire link target
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic       clk_sys, rst, haltIn, flashReadLoad, clkLine, hostOe, hostBit;
  logic [7:0] flashReadData, fpControl, flashWriteData, rd;
  logic       debugDataOut, debugDataOeN, resetPinToLink, portPinToLink;
  logic       flashDataStrobe, cmdBlockRead, cmdBlockWrite, linkBusy;
  logic       cmdPageErase, cmdDeviceErase;
  logic [3:0] cmdSeen = 4'h0;
  logic       busySeen = 1'h0;
  logic [7:0] cmds [5] = '{8'h06, 8'h07, 8'h08, 8'h03, 8'h55};
  int         num_errors, samples_checked, cycles;
  // pull-up holds the line high when nobody drives
  wire dataLine = !debugDataOeN ? debugDataOut : hostOe ? hostBit : 1'h1;
  twl_port #(.PART_ID(8'hc3), .REVISION(8'h2e)) u_dut (.clk_sys, .rst,
    .haltIn, .debugClockLine(clkLine), .debugDataIn(dataLine), .debugDataOut,
    .debugDataOeN, .resetPinToLink, .portPinToLink, .fpControl,
    .flashWriteData, .flashDataStrobe, .cmdBlockRead, .cmdBlockWrite,
    .cmdPageErase, .cmdDeviceErase, .flashReadLoad, .flashReadData, .linkBusy);
  twl_host u_host (.clkLine, .hostOe, .hostBit, .dataLine);
  initial begin
    clk_sys = 1'h0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (flashDataStrobe)
      cmdSeen <= {cmdDeviceErase, cmdPageErase, cmdBlockWrite, cmdBlockRead};
    if (linkBusy)
      busySeen <= 1'h1;
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      stop_test;
    end
  end
  task automatic stop_test;
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic link(input logic [1:0] ins, input logic [7:0] wd);
    // frames start on a falling edge so link pins never move on a rise
    @(negedge clk_sys);
    u_host.frame(ins, wd, rd);
  endtask
  initial begin
    rst = 1'h1;
    haltIn = 1'h0;
    flashReadLoad = 1'h0;
    flashReadData = 8'h00;
    repeat (8) @(posedge clk_sys);
    rst <= 1'h0;
    haltIn <= 1'h1;
    repeat (4) @(posedge clk_sys);
    check(fpControl, 8'h00);
    check({debugDataOeN, debugDataOut, linkBusy}, 8'h06);
    link(2'h2, 8'h00);
    check(rd, 8'h00);
    link(2'h0, 8'h00);
    check(rd, 8'hc3);
    link(2'h3, 8'h01);
    link(2'h0, 8'h00);
    check(rd, 8'h2e);
    link(2'h1, 8'hff);
    link(2'h0, 8'h00);
    check(rd, 8'h2e);
    link(2'h3, 8'h02);
    link(2'h1, 8'ha5);
    check(fpControl, 8'ha5);
    link(2'h0, 8'h00);
    check(rd, 8'ha5);
    link(2'h3, 8'hb4);
    link(2'h2, 8'h00);
    check(rd, 8'hb4);
    for (int i = 0; i < 5; i++) begin
      link(2'h1, cmds[i]);
      check(flashWriteData, cmds[i]);
      check(cmdSeen, (i < 4) ? 8'h01 << i : 8'h00);
    end
    link(2'h0, 8'h00);
    check(rd, 8'h55);
    @(posedge clk_sys);
    flashReadLoad <= 1'h1;
    flashReadData <= 8'h3c;
    @(posedge clk_sys);
    flashReadLoad <= 1'h0;
    link(2'h0, 8'h00);
    check(rd, 8'h3c);
    link(2'h3, 8'h33);
    link(2'h1, 8'h77);
    link(2'h0, 8'h00);
    check(rd, 8'h00);
    check(fpControl, 8'ha5);
    check(busySeen, 8'h01);
    link(2'h3, 8'h02);
    @(posedge clk_sys);
    haltIn <= 1'h0;
    repeat (2) @(posedge clk_sys);
    check({resetPinToLink, portPinToLink}, 8'h00);
    link(2'h1, 8'h11);
    check(fpControl, 8'ha5);
    @(posedge clk_sys);
    haltIn <= 1'h1;
    repeat (2) @(posedge clk_sys);
    check({resetPinToLink, portPinToLink}, 8'h03);
    link(2'h1, 8'h11);
    check(fpControl, 8'h11);
    stop_test;
  end
endmodule // tb_top
`default_nettype wire
